// *** hw/spi_eeprom_write_sequencer.sv ***
`timescale 1ns/10ps
module spi_eeprom_write_sequencer #(
	parameter int ADDR_W          = eeprom_wr_pkg::DEF_ADDR_W,
	parameter int PAGE_W          = eeprom_wr_pkg::DEF_PAGE_W,
	parameter bit LONG_ADDR       = 1'b1,
	parameter bit NINTH_IN_OPCODE = 1'b0,
	parameter int PROG_CYCLES     = eeprom_wr_pkg::PROG_CYCLES_DEF
) (
	// clock and reset
	input  wire logic              clk_sys,
	input  wire logic              rst,
	// serial link pins
	input  wire logic              sck,
	input  wire logic              csN,
	input  wire logic              si,
	input  wire logic              wpN,
	output logic                   soData,
	output logic                   soOe,
	// array program port
	output logic                   memWrValid,
	output logic      [ADDR_W-1:0] memWrAddr,
	output logic      [7:0]        memWrData,
	input  wire logic              memWrReady,
	// status view
	output logic      [7:0]        statusReg
);
	import eeprom_wr_pkg::*;

	localparam int PAGE_BYTES = 1 << PAGE_W;
	localparam int ADDR_BITS  = LONG_ADDR ? LONG_ADDR_BITS : SHORT_ADDR_BITS;
	localparam int ENTRY_W    = ADDR_W + 8;
	localparam int TIMER_W    = $clog2(PROG_CYCLES + 1);

	logic [3:0]         lvl;
	logic [3:0]         rise;
	logic [3:0]         fall;
	logic               sckRise;
	logic               sckFall;
	logic               csLow;
	logic               csFall;
	logic               csRise;
	logic               siBit;
	logic               wpLow;
	seq_t               state;
	cmd_t               cmd;
	logic [2:0]         bitCnt;
	logic [7:0]         shiftIn;
	logic [7:0]         byteNow;
	logic [7:0]         opMask;
	logic [3:0]         addrCnt;
	logic [15:0]        addrShift;
	logic [15:0]        next_addrShift;
	logic               ninthAddressBit;
	logic [ADDR_W-1:0]  wrAddr;
	logic [ADDR_W-1:0]  next_addr;
	logic               gotData;
	logic               gotSr;
	logic [7:0]         srData;
	logic               shiftTick;
	logic               byteDone;
	logic               addrLast;
	logic               wholeBytes;
	logic               commitWr;
	logic               commitSr;
	logic               commitSet;
	logic               commitClr;
	logic               srLocked;
	logic               writeLatchFlag;
	logic               busy;
	logic [7:0]         nvStatus;
	logic [7:0]         statusNow;
	logic [7:0]         statusView;
	logic [7:0]         pageBuf [PAGE_BYTES];
	logic [PAGE_BYTES-1:0] pageMark;
	prog_t              pgState;
	logic [PAGE_W-1:0]  drainIdx;
	logic [ADDR_W-1:0]  drainAddr;
	logic [TIMER_W-1:0] timer;
	logic               progDone;
	logic               fifoInValid;
	logic               fifoInReady;
	logic               fifoOutValid;
	logic               fifoOutReady;
	logic [ENTRY_W-1:0] fifoOutData;
	logic [2:0]         outCnt;
	logic [7:0]         outShift;

	function automatic logic isProtected(input logic [ADDR_W-1:0] a,
		input logic [2:0] bp);
		logic [ADDR_W-PAGE_W-1:0] pg;
		pg = a[ADDR_W-1:PAGE_W];
		if (bp == BP_NONE)
			isProtected = 1'b0;
		else if (bp <= BP_QLAST)
			isProtected = (a[ADDR_W-1 -: 2] == 2'(bp - 3'h1));
		else if (bp == BP_HALF)
			isProtected = !a[ADDR_W-1];
		else if (bp == BP_FIRST)
			isProtected = (pg == '0);
		else
			isProtected = &pg;
	endfunction

	// sck, cs, si and wp all come from another domain
	pin_sync #(
		.W    (4),
		.INIT (PIN_IDLE)
	) pin_sync_i (
		.clk_sys (clk_sys),
		.rst     (rst),
		.pinIn   ({wpN, si, csN, sck}),
		.level   (lvl),
		.rise    (rise),
		.fall    (fall)
	);

	assign sckRise   = rise[0];
	assign sckFall   = fall[0];
	assign csLow     = !lvl[1];
	assign csFall    = fall[1];
	assign csRise    = rise[1];
	assign siBit     = lvl[2];
	assign wpLow     = !lvl[3];
	// a rising bit edge that meets a select edge is dropped on the input path only
	assign shiftTick = sckRise && csLow && !csFall && !csRise;
	assign byteNow   = {shiftIn[6:0], siBit};
	assign byteDone  = shiftTick && (bitCnt == 3'h7);
	assign addrLast  = (addrCnt == 4'(ADDR_BITS - 1));
	assign opMask    = NINTH_IN_OPCODE ? ~OP_NINTH_MASK : 8'hff;
	assign busy      = (pgState != PG_IDLE);
	assign srLocked  = nvStatus[BIT_WP_EN] && wpLow;

	assign wholeBytes = csRise && (bitCnt == 3'h0) && !busy && writeLatchFlag;
	assign commitWr  = wholeBytes && (state == ST_DATA) && gotData;
	assign commitSr  = wholeBytes && (state == ST_SRIN) && gotSr && !srLocked;
	assign commitSet = csRise && (cmd == CMD_SET) && !busy;
	assign commitClr = csRise && (cmd == CMD_CLR) && !busy;

	always_comb begin
		next_addrShift = {addrShift[14:0], siBit};
		if (LONG_ADDR)
			next_addr = next_addrShift[ADDR_W-1:0];
		else if (NINTH_IN_OPCODE)
			next_addr = ADDR_W'({ninthAddressBit, next_addrShift[7:0]});
		else
			next_addr = ADDR_W'(next_addrShift[7:0]);
	end

	// command sequencer, cs fall always restarts it
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state <= ST_IDLE;
			cmd <= CMD_NONE;
			bitCnt <= 3'h0;
			shiftIn <= 8'h00;
			addrCnt <= 4'h0;
			addrShift <= 16'h0000;
			ninthAddressBit <= 1'b0;
			wrAddr <= '0;
			gotData <= 1'b0;
			gotSr <= 1'b0;
			srData <= 8'h00;
		end else if (csFall) begin
			state <= ST_OP;
			cmd <= CMD_NONE;
			bitCnt <= 3'h0;
			addrCnt <= 4'h0;
			gotData <= 1'b0;
			gotSr <= 1'b0;
		end else if (csRise) begin
			state <= ST_IDLE;
		end else if (shiftTick) begin
			shiftIn <= byteNow;
			bitCnt <= bitCnt + 3'h1;
			unique case (state)
			ST_OP: if (bitCnt == 3'h7) begin
				// unknown opcode parks until next select
				state <= ST_SKIP;
				if (byteNow == OP_LATCH_SET)
					cmd <= CMD_SET;
				else if (byteNow == OP_LATCH_CLR)
					cmd <= CMD_CLR;
				else if (byteNow == OP_STATUS_RD)
					state <= ST_SROUT;
				else if (byteNow == OP_STATUS_WR && !busy)
					state <= ST_SRIN;
				else if ((byteNow & opMask) == OP_WRITE && !busy) begin
					state <= ST_ADDR;
					ninthAddressBit <= byteNow[OP_NINTH_POS];
				end
			end
			ST_ADDR: begin
				addrShift <= next_addrShift;
				addrCnt <= addrCnt + 4'h1;
				if (addrLast) begin
					state <= ST_DATA;
					wrAddr <= next_addr;
				end
			end
			ST_DATA: if (byteDone) begin
				gotData <= 1'b1;
				// offset steps and wraps in page
				wrAddr[PAGE_W-1:0] <= wrAddr[PAGE_W-1:0] + 1'b1;
			end
			ST_SRIN: if (byteDone) begin
				srData <= byteNow;
				gotSr <= 1'b1;
			end
			ST_IDLE, ST_SROUT, ST_SKIP: begin
			end
			default: state <= ST_SKIP;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (byteDone && state == ST_DATA)
			pageBuf[wrAddr[PAGE_W-1:0]] <= byteNow;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			pageMark <= '0;
		else if (shiftTick && state == ST_ADDR && addrLast)
			pageMark <= '0;
		else if (byteDone && state == ST_DATA)
			pageMark[wrAddr[PAGE_W-1:0]] <= 1'b1;
	end

	// latch clear at reset and after a cycle
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			writeLatchFlag <= 1'b0;
		else if (commitSet)
			writeLatchFlag <= 1'b1;
		else if (commitClr || progDone)
			writeLatchFlag <= 1'b0;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			nvStatus <= STATUS_NV_RESET;
		else if (commitSr)
			nvStatus <= (nvStatus & ~STATUS_WR_MASK) | (srData & STATUS_WR_MASK);
	end

	always_comb begin
		statusNow = (nvStatus & STATUS_WR_MASK) | STATUS_FIXED_ONES;
		statusNow[BIT_LATCH] = writeLatchFlag;
		statusNow[BIT_BUSY] = busy;
	end

	assign statusView = busy ? STATUS_BUSY_VIEW : statusNow;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			statusReg <= STATUS_FIXED_ONES;
		else
			statusReg <= statusNow;
	end

	assign drainAddr   = {wrAddr[ADDR_W-1:PAGE_W], drainIdx};
	assign fifoInValid = (pgState == PG_DRAIN) && pageMark[drainIdx]
		&& !isProtected(drainAddr, nvStatus[BIT_BP_LO +: 3]);
	// busy covers drain, timer and output
	assign progDone = (pgState == PG_WAIT) && (timer == TIMER_W'(PROG_CYCLES - 1))
		&& !fifoOutValid && !memWrValid;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pgState <= PG_IDLE;
			drainIdx <= '0;
			timer <= '0;
		end else begin
			unique case (pgState)
			PG_IDLE: begin
				drainIdx <= '0;
				timer <= '0;
				if (commitWr)
					pgState <= PG_DRAIN;
				else if (commitSr)
					pgState <= PG_WAIT;
			end
			PG_DRAIN: if (!fifoInValid || fifoInReady) begin
				drainIdx <= drainIdx + 1'b1;
				if (drainIdx == PAGE_W'(PAGE_BYTES - 1))
					pgState <= PG_WAIT;
			end
			PG_WAIT: begin
				if (timer != TIMER_W'(PROG_CYCLES - 1))
					timer <= timer + 1'b1;
				else if (progDone)
					pgState <= PG_IDLE;
			end
			default: pgState <= PG_IDLE;
			endcase
		end
	end

	stream_fifo #(
		.WIDTH (ENTRY_W),
		.DEPTH (FIFO_DEPTH)
	) stream_fifo_i (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.inValid  (fifoInValid),
		.inReady  (fifoInReady),
		.inData   ({drainAddr, pageBuf[drainIdx]}),
		.outValid (fifoOutValid),
		.outReady (fifoOutReady),
		.outData  (fifoOutData)
	);

	// a stalled array port backs up into the drain walk
	assign fifoOutReady = !memWrValid || memWrReady;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			memWrValid <= 1'b0;
			memWrAddr <= '0;
			memWrData <= 8'h00;
		end else if (fifoOutReady) begin
			memWrValid <= fifoOutValid;
			if (fifoOutValid) begin
				memWrAddr <= fifoOutData[ENTRY_W-1:8];
				memWrData <= fifoOutData[7:0];
			end
		end
	end

	// output driven only by status read
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			soOe <= 1'b0;
			soData <= 1'b0;
			outCnt <= 3'h0;
			outShift <= 8'h00;
		end else if (state != ST_SROUT) begin
			soOe <= 1'b0;
			outCnt <= 3'h0;
		end else if (sckFall) begin
			soOe <= 1'b1;
			outCnt <= outCnt + 3'h1;
			if (outCnt == 3'h0) begin
				soData <= statusView[7];
				outShift <= {statusView[6:0], 1'b0};
			end else begin
				soData <= outShift[7];
				outShift <= {outShift[6:0], 1'b0};
			end
		end
	end

	property p_start_on_rise;
		@(posedge clk_sys) disable iff (rst)
		(pgState == PG_IDLE) ##1 (pgState != PG_IDLE) |-> $past(csRise);
	endproperty
	a_start_on_rise: assert property (p_start_on_rise)
		else $error("program started without chip select rise");

	property p_latch_cleared;
		@(posedge clk_sys) disable iff (rst)
		progDone |=> !writeLatchFlag && !busy;
	endproperty
	a_latch_cleared: assert property (p_latch_cleared)
		else $error("write latch survived a finished cycle");

	property p_needs_latch;
		@(posedge clk_sys) disable iff (rst)
		(csRise && !writeLatchFlag && pgState == PG_IDLE) |=> !busy;
	endproperty
	a_needs_latch: assert property (p_needs_latch)
		else $error("cycle started without write latch");

	property p_status_fixed;
		@(posedge clk_sys) disable iff (rst)
		1'b1 |=> ((nvStatus ^ $past(nvStatus)) & ~STATUS_WR_MASK) == 8'h00;
	endproperty
	a_status_fixed: assert property (p_status_fixed)
		else $error("read-only status bit changed");

	property p_whole_bytes;
		@(posedge clk_sys) disable iff (rst)
		(csRise && bitCnt != 3'h0 && !busy) |=> !busy;
	endproperty
	a_whole_bytes: assert property (p_whole_bytes)
		else $error("cycle started off a byte boundary");

	property p_busy_ignore;
		@(posedge clk_sys) disable iff (rst)
		busy |-> !(state inside {ST_ADDR, ST_DATA, ST_SRIN});
	endproperty
	a_busy_ignore: assert property (p_busy_ignore)
		else $error("array command accepted while busy");

	property p_so_quiet;
		@(posedge clk_sys) disable iff (rst)
		(state != ST_SROUT) ##1 (state != ST_SROUT) |-> !soOe;
	endproperty
	a_so_quiet: assert property (p_so_quiet)
		else $error("serial output driven outside status read");

	property p_page_step;
		@(posedge clk_sys) disable iff (rst)
		(byteDone && state == ST_DATA) |=>
			wrAddr[PAGE_W-1:0] == $past(wrAddr[PAGE_W-1:0]) + 1'b1
			&& wrAddr[ADDR_W-1:PAGE_W] == $past(wrAddr[ADDR_W-1:PAGE_W]);
	endproperty
	a_page_step: assert property (p_page_step)
		else $error("page address stepped wrongly");

	property p_busy_bit;
		@(posedge clk_sys) disable iff (rst)
		1'b1 |=> statusReg[BIT_BUSY] == $past(busy);
	endproperty
	a_busy_bit: assert property (p_busy_bit)
		else $error("status busy bit does not track cycle");

	property p_protect;
		@(posedge clk_sys) disable iff (rst)
		memWrValid |-> !isProtected(memWrAddr, nvStatus[BIT_BP_LO +: 3]);
	endproperty
	a_protect: assert property (p_protect)
		else $error("protected location sent to the array");

	property p_busy_high;
		@(posedge clk_sys) disable iff (rst)
		(sckFall && state == ST_SROUT && busy) |=> soData && soOe;
	endproperty
	a_busy_high: assert property (p_busy_high)
		else $error("status read not high while busy");
endmodule

// *** shared/eeprom_wr_pkg.sv ***
package eeprom_wr_pkg;

	// command bytes, tunable per product
	localparam logic [7:0] OP_LATCH_SET  = 8'h06;
	localparam logic [7:0] OP_LATCH_CLR  = 8'h04;
	localparam logic [7:0] OP_STATUS_RD  = 8'h05;
	localparam logic [7:0] OP_STATUS_WR  = 8'h01;
	localparam logic [7:0] OP_WRITE      = 8'h02;
	localparam logic [7:0] OP_NINTH_MASK = 8'h08;
	localparam int         OP_NINTH_POS  = 3;

	// status layout
	localparam logic [7:0] STATUS_WR_MASK    = 8'h9c;
	localparam logic [7:0] STATUS_FIXED_ONES = 8'h60;
	localparam logic [7:0] STATUS_NV_RESET   = 8'h00;
	localparam logic [7:0] STATUS_BUSY_VIEW  = 8'hff;
	localparam int         BIT_BUSY          = 0;
	localparam int         BIT_LATCH         = 1;
	localparam int         BIT_BP_LO         = 2;
	localparam int         BIT_WP_EN         = 7;

	// block protect codes
	localparam logic [2:0] BP_NONE  = 3'h0;
	localparam logic [2:0] BP_QLAST = 3'h4;
	localparam logic [2:0] BP_HALF  = 3'h5;
	localparam logic [2:0] BP_FIRST = 3'h6;

	// geometry and timing
	localparam int         LONG_ADDR_BITS  = 16;
	localparam int         SHORT_ADDR_BITS = 8;
	localparam int         DEF_ADDR_W      = 11;
	localparam int         DEF_PAGE_W      = 5;
	localparam int         FIFO_DEPTH      = 4;
	localparam int         PROG_TIME_US    = 5000;
	localparam int         CLK_PERIOD_NS   = 25;
	localparam int         PROG_CYCLES_DEF =
		PROG_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam logic [3:0] PIN_IDLE        = 4'ha;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_OP    = 3'b001,
		ST_ADDR  = 3'b010,
		ST_DATA  = 3'b011,
		ST_SRIN  = 3'b100,
		ST_SROUT = 3'b101,
		ST_SKIP  = 3'b110
	} seq_t;

	typedef enum logic [1:0] {
		PG_IDLE  = 2'b00,
		PG_DRAIN = 2'b01,
		PG_WAIT  = 2'b10
	} prog_t;

	typedef enum logic [1:0] {
		CMD_NONE = 2'b00,
		CMD_SET  = 2'b01,
		CMD_CLR  = 2'b10
	} cmd_t;

endpackage

// *** hw/pin_sync.sv ***
`timescale 1ns/10ps
module pin_sync #(
	parameter int           W    = 1,
	parameter logic [W-1:0] INIT = '0
) (
	// clock and reset
	input  wire logic         clk_sys,
	input  wire logic         rst,
	// raw pins and their synced view
	input  wire logic [W-1:0] pinIn,
	output logic      [W-1:0] level,
	output logic      [W-1:0] rise,
	output logic      [W-1:0] fall
);
	logic [W-1:0] meta;
	logic [W-1:0] stable;
	logic [W-1:0] prev;

	// idle levels at reset avoid a false edge after release
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			meta <= INIT;
			stable <= INIT;
			prev <= INIT;
		end else begin
			meta <= pinIn;
			stable <= meta;
			prev <= stable;
		end
	end

	assign level = stable;
	assign rise  = stable & ~prev;
	assign fall  = ~stable & prev;
endmodule

// *** hw/stream_fifo.sv ***
`timescale 1ns/10ps
module stream_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rst,
	// fill side
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	// drain side
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] store [DEPTH];
	logic [AW-1:0]    wrPtr;
	logic [AW-1:0]    rdPtr;
	logic [AW:0]      count;
	logic             push;
	logic             pop;

	assign inReady  = (count != (AW+1)'(DEPTH));
	assign outValid = (count != '0);
	assign outData  = store[rdPtr];
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;

	always_ff @(posedge clk_sys) begin
		if (push)
			store[wrPtr] <= inData;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end else begin
			if (push)
				wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
			if (pop)
				rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// *** testbench/spi_host_model.sv ***
`timescale 1ns/10ps
module spi_host_model (
	// clock
	input  wire logic clk_sys,
	// link pins
	output logic      sck,
	output logic      csN,
	output logic      si,
	input  wire logic soData,
	input  wire logic soOe
);
	logic last;

	initial begin
		sck = 1'b0;
		csN = 1'b1;
		si = 1'b0;
		last = 1'b0;
	end

	task automatic sel();
		@(posedge clk_sys);
		csN <= 1'b0;
		repeat (4) @(posedge clk_sys);
	endtask

	// rise only after last sck fall
	task automatic desel();
		repeat (4) @(posedge clk_sys);
		csN <= 1'b1;
		repeat (8) @(posedge clk_sys);
	endtask

	// msb first, mode 0
	// eight clocks a bit gives the 200 ns link period
	task automatic xfer(input logic [7:0] tx, input int n,
			output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 0; i < n; i++) begin
			si <= tx[7-i];
			repeat (4) @(posedge clk_sys);
			sck <= 1'b1;
			repeat (4) @(posedge clk_sys);
			// a released line shows the inverse of its last bit
			last = (soOe === 1'b1) ? soData : ~last;
			rx = {rx[6:0], last};
			sck <= 1'b0;
		end
	endtask
endmodule

// *** testbench/spi_eeprom_write_sequencer_bench.sv ***
`timescale 1ns/10ps
module spi_eeprom_write_sequencer_bench;
	import eeprom_wr_pkg::*;
	// long enough to hold two selects inside one busy span
	localparam int PC = 600;
	logic        clk_sys, rst, sck, csN, si, wpN, soData, soOe;
	logic        memWrValid, memWrReady, stall;
	logic [10:0] memWrAddr;
	logic [7:0]  memWrData, statusReg, rx;
	logic [10:0] gotA[$];
	logic [7:0]  gotD[$];
	int          mismatches, checks_done;
	int          cyc = 0;

	spi_eeprom_write_sequencer #(.PROG_CYCLES(PC)) spi_eeprom_write_sequencer_i (
		.clk_sys(clk_sys), .rst(rst), .sck(sck), .csN(csN), .si(si),
		.wpN(wpN), .soData(soData), .soOe(soOe),
		.memWrValid(memWrValid), .memWrAddr(memWrAddr),
		.memWrData(memWrData), .memWrReady(memWrReady),
		.statusReg(statusReg));

	spi_host_model spi_host_model_i (
		.clk_sys(clk_sys), .sck(sck), .csN(csN), .si(si),
		.soData(soData), .soOe(soOe));

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	// stalling array side lets the buffer fill up
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		memWrReady <= !stall || (cyc % 5 == 0);
		if (memWrValid === 1'b1 && memWrReady === 1'b1) begin
			gotA.push_back(memWrAddr);
			gotD.push_back(memWrData);
		end
	end

	task automatic check(input string nm, input logic [15:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic cmd(input logic [7:0] op, input logic [7:0] arg, int n);
		spi_host_model_i.sel();
		spi_host_model_i.xfer(op, 8, rx);
		spi_host_model_i.xfer(arg, n, rx);
		spi_host_model_i.desel();
	endtask

	task automatic wr(input logic [15:0] a, input int n, tail, pre);
		spi_host_model_i.sel();
		if (pre)
			spi_host_model_i.xfer(OP_LATCH_SET, 8, rx);
		spi_host_model_i.xfer(OP_WRITE, 8, rx);
		spi_host_model_i.xfer(a[15:8], 8, rx);
		spi_host_model_i.xfer(a[7:0], 8, rx);
		for (int i = 0; i < n; i++)
			spi_host_model_i.xfer(8'(i + 1), 8, rx);
		spi_host_model_i.xfer(8'h00, tail, rx);
		check("validEarly", 16'(memWrValid), 16'h0000);
		spi_host_model_i.desel();
	endtask

	task automatic wait_idle();
		for (int i = 0; i < 4000 && statusReg[0] !== 1'b0; i++)
			@(posedge clk_sys);
		check("idle", 16'(statusReg[0]), 16'h0000);
		repeat (4) @(posedge clk_sys);
	endtask

	task automatic t_reset();
		check("status", 16'(statusReg), 16'h0060);
		check("soOe", 16'(soOe), 16'h0000);
		check("valid", 16'(memWrValid), 16'h0000);
	endtask

	task automatic t_refused();
		spi_host_model_i.sel();
		spi_host_model_i.desel();
		wr(16'h0010, 1, 0, 0);
		wr(16'h0010, 1, 0, 1);
		cmd(OP_LATCH_SET, 8'h00, 0);
		wr(16'h0010, 1, 3, 0);
		wait_idle();
		check("refusedWrites", 16'(gotA.size()), 16'h0000);
		cmd(OP_LATCH_CLR, 8'h00, 0);
		check("latchClr", 16'(statusReg), 16'h0060);
	endtask

	task automatic t_page();
		cmd(OP_LATCH_SET, 8'h00, 0);
		check("latch", 16'(statusReg), 16'h0062);
		stall <= 1'b1;
		wr(16'hfc3f, 33, 0, 0);
		check("busy", 16'(statusReg[0]), 16'h0001);
		cmd(OP_STATUS_RD, 8'h00, 8);
		check("busyRead", 16'(rx), 16'h00ff);
		cmd(OP_STATUS_WR, 8'h9c, 8);
		wait_idle();
		stall <= 1'b0;
		check("done", 16'(statusReg), 16'h0060);
		check("words", 16'(gotA.size()), 16'h0020);
		for (int j = 0; j < 32 && j < gotA.size(); j++) begin
			check("addr", 16'(gotA[j]), 16'(11'h420 + j));
			check("data", 16'(gotD[j]), (j == 31) ? 16'h0021 : 16'(j + 2));
		end
		cmd(OP_STATUS_RD, 8'h00, 8);
		check("readyRead", 16'(rx), 16'h0060);
		gotA.delete();
		gotD.delete();
	endtask

	task automatic t_status();
		cmd(OP_LATCH_SET, 8'h00, 0);
		cmd(OP_STATUS_WR, 8'hff, 8);
		wait_idle();
		check("statusMask", 16'(statusReg), 16'h00fc);
		// protect pin low with its enable bit set locks the status byte
		wpN <= 1'b0;
		cmd(OP_LATCH_SET, 8'h00, 0);
		cmd(OP_STATUS_WR, 8'h00, 8);
		check("statusLocked", 16'(statusReg), 16'h00fe);
		wpN <= 1'b1;
		cmd(OP_LATCH_SET, 8'h00, 0);
		wr(16'h07e5, 1, 0, 0);
		wait_idle();
		check("protected", 16'(gotA.size()), 16'h0000);
		cmd(OP_LATCH_SET, 8'h00, 0);
		cmd(OP_STATUS_WR, 8'h00, 8);
		wait_idle();
		check("statusBack", 16'(statusReg), 16'h0060);
	endtask

	task automatic t_badop();
		spi_host_model_i.sel();
		spi_host_model_i.xfer(8'hab, 8, rx);
		spi_host_model_i.xfer(OP_STATUS_RD, 8, rx);
		spi_host_model_i.xfer(8'h00, 8, rx);
		check("badOpSo", 16'(soOe), 16'h0000);
		spi_host_model_i.desel();
		check("badOpStatus", 16'(statusReg), 16'h0060);
	endtask

	initial begin
		rst = 1'b1;
		wpN = 1'b1;
		stall = 1'b0;
		mismatches = 0;
		checks_done = 0;
		repeat (12) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (4) @(posedge clk_sys);
		t_reset();
		t_refused();
		t_page();
		t_status();
		t_badop();
		wrap_up();
	end

	// generous over the roughly 8k cycles the tests need
	initial begin
		#1250000;
		mismatches++;
		wrap_up();
	end
endmodule
